// File: verilog/pli_pkg.sv
// Package: constants and types shared by the port indicator logic
package pli_pkg;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int PLI_PORTS = 4;
  localparam int PLI_CNT_W = 21;
  localparam int PLI_ADDR_W = 12;
  localparam int PLI_DATA_W = 32;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [11:0] PLI_GLOBAL_CTL_ADDR = 12'h0b1;
  localparam logic [11:0] PLI_PORT_CTL_ADDR = 12'h0b2;
  localparam logic [PLI_PORTS-1:0] PLI_PORT_CTL_RST = 4'h0;
  localparam logic PLI_GLOBAL_CTL_RST = 1'h0;
  // Read-only status fields placed above the control bits
  localparam int PLI_GLOBAL_FORCE_BIT = 0;
  localparam int PLI_GLOBAL_FAULT_BIT = 8;
  localparam int PLI_PORT_FORCE_LSB = 0;
  localparam int PLI_PORT_ACT_LSB = 8;
  localparam int PLI_PORT_LINK_LSB = 16;
  localparam int PLI_PORT_SPEED_LSB = 24;

  // ------------------------------------------------------------------
  // Timing at the 25 MHz core clock
  // ------------------------------------------------------------------
  localparam int PLI_CLK_KHZ = 25000;
  localparam int PLI_ACT_PULSE_MS = 20;
  localparam int PLI_FAST_BLINK_MS = 50;
  localparam int PLI_ACT_PULSE_CYC = PLI_ACT_PULSE_MS * PLI_CLK_KHZ;
  localparam int PLI_FAST_BLINK_CYC = PLI_FAST_BLINK_MS * PLI_CLK_KHZ;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic link_up;
    logic partitioned;
    logic isolated;
    logic speed_100;
    logic autoneg_en;
    logic rx_activity;
  } pli_port_status_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [PLI_ADDR_W-1:0] addr;
    logic [PLI_DATA_W-1:0] wdata;
  } pli_reg_req_type;

  typedef struct packed {
    logic [PLI_CNT_W-1:0] cnt;
    logic on;
  } pli_pulse_state_type;

  typedef struct packed {
    logic [PLI_PORTS-1:0] link;
    logic [PLI_PORTS-1:0] act;
    logic [PLI_PORTS-1:0] speed;
    logic fault;
    logic [PLI_CNT_W-1:0] blink_cnt;
    logic blink_ph;
    logic [PLI_PORTS-1:0] port_ctl;
    logic global_ctl;
    logic [PLI_DATA_W-1:0] rdata;
  } pli_top_state_type;

endpackage : pli_pkg

// File: verilog/pli_pulse.sv
// Retriggerable pulse stretcher for one port's receive activity
`timescale 1ns/1ps

module pli_pulse
  import pli_pkg::*;
#(
  parameter int PULSE_CYC = PLI_ACT_PULSE_CYC
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_trigger,
  output logic o_pulse
);

  localparam logic [PLI_CNT_W-1:0] LOAD = PLI_CNT_W'(PULSE_CYC - 1);

  pli_pulse_state_type state_ff;
  pli_pulse_state_type nxt_state;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    // Fresh activity restarts the window so a busy port stays lit
    if (i_trigger)
    begin
      nxt_state.cnt = LOAD;
      nxt_state.on = 1'b1;
    end
    else if (state_ff.cnt != '0)
    begin
      nxt_state.cnt = state_ff.cnt - PLI_CNT_W'(1);
    end
    else
    begin
      nxt_state.on = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign o_pulse = state_ff.on;

endmodule : pli_pulse

// File: verilog/pli_top.sv
// Port and global LED indicator logic of the repeater
`timescale 1ns/1ps

module pli_top
  import pli_pkg::*;
#(
  parameter int ACT_PULSE_CYC = PLI_ACT_PULSE_CYC,
  parameter int FAST_BLINK_CYC = PLI_FAST_BLINK_CYC
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire pli_port_status_type [PLI_PORTS-1:0] i_port,
  input wire logic i_supply_fault,
  input wire logic i_blink_disable,
  input wire pli_reg_req_type i_reg,
  output logic [PLI_PORTS-1:0] o_port_link_indicator,
  output logic [PLI_PORTS-1:0] o_port_activity_indicator,
  output logic [PLI_PORTS-1:0] o_port_speed_indicator,
  output logic o_global_fault_indicator,
  output logic [PLI_DATA_W-1:0] o_reg_rdata
);

  localparam logic [PLI_CNT_W-1:0] BLINK_LAST =
    PLI_CNT_W'(FAST_BLINK_CYC - 1);

  pli_top_state_type state_ff;
  pli_top_state_type nxt_state;
  logic [PLI_PORTS-1:0] act_pulse;

  // ------------------------------------------------------------------
  // Activity stretchers, one per port
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PLI_PORTS; gi++)
    begin : g_act
      pli_pulse
      #(
        .PULSE_CYC(ACT_PULSE_CYC)
      )
      u_pulse
      (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_trigger(i_port[gi].rx_activity),
        .o_pulse(act_pulse[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic any_fault;
    logic [PLI_DATA_W-1:0] rd;
    any_fault = i_supply_fault;
    rd = '0;
    nxt_state = state_ff;

    // ----------------------------------------------------------------
    // Fast blink phase
    // ----------------------------------------------------------------
    // Shared by every port so that all blinking ports stay in step
    if (state_ff.blink_cnt == BLINK_LAST)
    begin
      nxt_state.blink_cnt = '0;
      nxt_state.blink_ph = ~state_ff.blink_ph;
    end
    else
    begin
      nxt_state.blink_cnt = state_ff.blink_cnt + PLI_CNT_W'(1);
    end

    // ----------------------------------------------------------------
    // Per-port indicators
    // ----------------------------------------------------------------
    for (int p = 0; p < PLI_PORTS; p++)
    begin
      // Isolation only darkens a port that runs at 100M
      if (i_port[p].speed_100)
      begin
        nxt_state.link[p] = i_port[p].link_up
          && !i_port[p].partitioned
          && !i_port[p].isolated;
      end
      else
      begin
        nxt_state.link[p] = i_port[p].link_up
          && !i_port[p].partitioned;
      end

      // Software hold wins over fresh activity
      if (state_ff.port_ctl[p])
      begin
        nxt_state.act[p] = 1'b0;
      end
      else
      begin
        nxt_state.act[p] = act_pulse[p];
      end

      // A fixed speed is shown even with the link down
      if (!i_port[p].autoneg_en)
      begin
        nxt_state.speed[p] = i_port[p].speed_100;
      end
      else if (i_port[p].link_up)
      begin
        nxt_state.speed[p] = i_port[p].speed_100;
      end
      else if (i_blink_disable)
      begin
        nxt_state.speed[p] = 1'b0;
      end
      else
      begin
        nxt_state.speed[p] = state_ff.blink_ph;
      end

      if (i_port[p].partitioned || i_port[p].isolated)
      begin
        any_fault = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Global fault indicator
    // ----------------------------------------------------------------
    if (state_ff.global_ctl)
    begin
      nxt_state.fault = 1'b0;
    end
    else
    begin
      nxt_state.fault = any_fault;
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (i_reg.wr)
    begin
      case (i_reg.addr)
        PLI_GLOBAL_CTL_ADDR:
        begin
          nxt_state.global_ctl = i_reg.wdata[PLI_GLOBAL_FORCE_BIT];
        end
        PLI_PORT_CTL_ADDR:
        begin
          nxt_state.port_ctl =
            i_reg.wdata[PLI_PORT_FORCE_LSB +: PLI_PORTS];
        end
        default:
        begin
          // Stray writes must not touch the force bits
          nxt_state.port_ctl = state_ff.port_ctl;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    // Read data holds between reads, so a slow master may take it late
    if (i_reg.rd)
    begin
      case (i_reg.addr)
        PLI_GLOBAL_CTL_ADDR:
        begin
          rd[PLI_GLOBAL_FORCE_BIT] = state_ff.global_ctl;
          rd[PLI_GLOBAL_FAULT_BIT] = any_fault;
        end
        PLI_PORT_CTL_ADDR:
        begin
          rd[PLI_PORT_FORCE_LSB +: PLI_PORTS] = state_ff.port_ctl;
          rd[PLI_PORT_ACT_LSB +: PLI_PORTS] = state_ff.act;
          rd[PLI_PORT_LINK_LSB +: PLI_PORTS] = state_ff.link;
          rd[PLI_PORT_SPEED_LSB +: PLI_PORTS] = state_ff.speed;
        end
        default:
        begin
          // Unmapped addresses read as zero
          rd = '0;
        end
      endcase
      nxt_state.rdata = rd;
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_ff <= '0;
      state_ff.port_ctl <= PLI_PORT_CTL_RST;
      state_ff.global_ctl <= PLI_GLOBAL_CTL_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign o_port_link_indicator = state_ff.link;
  assign o_port_activity_indicator = state_ff.act;
  assign o_port_speed_indicator = state_ff.speed;
  assign o_global_fault_indicator = state_ff.fault;
  assign o_reg_rdata = state_ff.rdata;

endmodule : pli_top

// File: test/pli_checker.sv
// Checker: concurrent assertions on the indicator block ports
`timescale 1ns/1ps
module pli_checker
  import pli_pkg::*;
#(
  parameter int ACT_PULSE_CYC = PLI_ACT_PULSE_CYC,
  parameter int FAST_BLINK_CYC = PLI_FAST_BLINK_CYC
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire pli_port_status_type [PLI_PORTS-1:0] i_port,
  input wire logic i_supply_fault,
  input wire logic i_blink_disable,
  input wire pli_reg_req_type i_reg,
  input wire logic [PLI_PORTS-1:0] o_port_link_indicator,
  input wire logic [PLI_PORTS-1:0] o_port_activity_indicator,
  input wire logic [PLI_PORTS-1:0] o_port_speed_indicator,
  input wire logic o_global_fault_indicator,
  input wire logic [PLI_DATA_W-1:0] o_reg_rdata
);
  pli_port_status_type p;
  logic flt, fc_ff, gc_ff;
  int idle_ff;
  assign p = i_port[0];
  // Edges since port 0 last saw activity, held once past the window
  always_ff @(posedge i_ref_clk or posedge i_rst)
    if (i_rst)
      idle_ff <= 0;
    else if (p.rx_activity)
      idle_ff <= 0;
    else if (idle_ff <= ACT_PULSE_CYC)
      idle_ff <= idle_ff + 1;
  // Force bits mirrored so forced-dark cycles do not trip the checks
  always_ff @(posedge i_ref_clk or posedge i_rst)
    if (i_rst)
      {fc_ff, gc_ff} <= 2'b00;
    else if (i_reg.wr && i_reg.addr == PLI_PORT_CTL_ADDR)
      fc_ff <= i_reg.wdata[0];
    else if (i_reg.wr && i_reg.addr == PLI_GLOBAL_CTL_ADDR)
      gc_ff <= i_reg.wdata[0];
  always_comb
  begin
    flt = i_supply_fault;
    for (int k = 0; k < PLI_PORTS; k++)
      flt = flt | i_port[k].partitioned | i_port[k].isolated;
  end
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  AST_LINK_10: assert property (!$past(i_rst) && !$past(p.speed_100)
    |-> o_port_link_indicator[0] == $past(p.link_up && !p.partitioned))
    else $error("link 10M");
  AST_LINK_100: assert property (!$past(i_rst) && $past(p.speed_100)
    |-> o_port_link_indicator[0] ==
    $past(p.link_up && !p.partitioned && !p.isolated)) else $error("link");
  AST_ACT: assert property (p.rx_activity
    |-> ##2 (o_port_activity_indicator[0] || $past(fc_ff))) else $error("act");
  AST_SPD_FIX: assert property (!$past(i_rst) && !$past(p.autoneg_en)
    |-> o_port_speed_indicator[0] == $past(p.speed_100)) else $error("spd");
  AST_SPD_AN: assert property (!$past(i_rst) && $past(p.autoneg_en &&
    (p.link_up || i_blink_disable)) |-> o_port_speed_indicator[0] ==
    $past(p.speed_100 && p.link_up)) else $error("spd an");
  AST_FAULT: assert property (!$past(i_rst) |->
    o_global_fault_indicator == $past(flt && !gc_ff)) else $error("fault");
  AST_FORCE: assert property (fc_ff |=> !o_port_activity_indicator[0])
    else $error("force");
  AST_ACT_END: assert property (idle_ff > ACT_PULSE_CYC
    |-> !o_port_activity_indicator[0]) else $error("act end");
  cover property (o_port_activity_indicator[0]);
  cover property (o_global_fault_indicator);
  cover property (!p.link_up ##1 o_port_speed_indicator[0]);
endmodule : pli_checker

// File: test/pli_top_tb.sv
// Testbench: self-checking run of the indicator block
`timescale 1ns/1ps
module pli_top_tb
  import pli_pkg::*;
();
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_supply_fault = 1'b0;
  logic i_blink_disable = 1'b0;
  logic [5:0] st = '0;
  pli_reg_req_type i_reg = '0;
  pli_port_status_type [PLI_PORTS-1:0] i_port;
  logic [3:0] lk, ac, sp;
  logic flt;
  logic [31:0] rd;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  localparam int ACT_CYC = 20;
  localparam int BLINK_CYC = 8;
  assign i_port = {4{st}};
  always #20 i_ref_clk = ~i_ref_clk;
  pli_top #(.ACT_PULSE_CYC(ACT_CYC), .FAST_BLINK_CYC(BLINK_CYC)) u_dut (
    .i_ref_clk, .i_rst, .i_port, .i_supply_fault, .i_blink_disable, .i_reg,
    .o_port_link_indicator(lk), .o_port_activity_indicator(ac),
    .o_port_speed_indicator(sp), .o_global_fault_indicator(flt),
    .o_reg_rdata(rd));
  always @(posedge i_ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_mismatch++;
      results();
    end
  end
  task automatic cmp(input logic [3:0] g, input logic [3:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  // Status order: link, partitioned, isolated, 100M, autoneg, rx
  task automatic go(input logic [5:0] v, input int n);
    @(posedge i_ref_clk);
    st <= v;
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : go
  task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] d);
    @(posedge i_ref_clk);
    i_reg <= {w, !w, a, 28'h0, d};
    @(posedge i_ref_clk);
    i_reg <= '0;
    #1;
  endtask : acc
  task automatic t_link;
    logic [3:0] m;
    for (int i = 0; i < 16; i++)
    begin
      m = 4'(i);
      go({m, 2'b00}, 2);
      cmp(lk, {4{m[3] & !m[2] & !(m[1] & m[0])}});
      cmp(sp, {4{m[0]}});
      cmp({3'h0, flt}, {3'h0, m[2] | m[1]});
    end
    go(6'h01, 1);
    go(6'h00, 4);
    cmp(ac, 4'hf);
    // Activity is still taken at the edge the next call clears it on
    go(6'h00, ACT_CYC - 5);
    cmp(ac, 4'hf);
    go(6'h00, 0);
    cmp(ac, 4'h0);
    $display("link and activity done");
  endtask : t_link
  task automatic t_speed;
    logic [3:0] hi, lo;
    go(6'h36, 2);
    cmp(sp, 4'hf);
    go(6'h22, 2);
    cmp(sp, 4'h0);
    hi = 4'h0;
    lo = 4'hf;
    repeat (20)
    begin
      go(6'h02, 1);
      hi |= sp;
      lo &= sp;
    end
    cmp(hi, 4'hf);
    cmp(lo, 4'h0);
    @(posedge i_ref_clk);
    i_blink_disable <= 1'b1;
    go(6'h02, 2 * BLINK_CYC);
    cmp(sp, 4'h0);
    @(posedge i_ref_clk);
    i_blink_disable <= 1'b0;
    $display("speed done");
  endtask : t_speed
  task automatic t_force;
    @(posedge i_ref_clk);
    i_supply_fault <= 1'b1;
    go(6'h20, 2);
    cmp({3'h0, flt}, 4'h1);
    acc(1'b1, PLI_GLOBAL_CTL_ADDR, 4'h1);
    go(6'h20, 2);
    cmp({3'h0, flt}, 4'h0);
    acc(1'b0, PLI_GLOBAL_CTL_ADDR, 4'h0);
    cmp(rd[3:0], 4'h1);
    acc(1'b1, PLI_PORT_CTL_ADDR, 4'hf);
    go(6'h21, 1);
    go(6'h20, 3);
    cmp(ac, 4'h0);
    acc(1'b0, PLI_PORT_CTL_ADDR, 4'h0);
    cmp(rd[3:0], 4'hf);
    acc(1'b0, 12'h0b3, 4'h0);
    cmp({3'h0, |rd}, 4'h0);
    acc(1'b1, PLI_PORT_CTL_ADDR, 4'h0);
    acc(1'b1, PLI_GLOBAL_CTL_ADDR, 4'h0);
    go(6'h21, 3);
    cmp(ac, 4'hf);
    $display("force done");
  endtask : t_force
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  initial
  begin
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_link();
    t_speed();
    t_force();
    results();
  end
endmodule : pli_top_tb
bind pli_top pli_checker #(.ACT_PULSE_CYC(ACT_PULSE_CYC),
  .FAST_BLINK_CYC(FAST_BLINK_CYC)) u_chk (.i_ref_clk, .i_rst, .i_port,
  .i_supply_fault, .i_blink_disable, .i_reg, .o_port_link_indicator,
  .o_port_activity_indicator, .o_port_speed_indicator,
  .o_global_fault_indicator, .o_reg_rdata);
